// file: src/acc_pkg.sv
// constants and types shared by the converter control block
//
// Notes on behaviour
// - right justify, 10-bit: low byte holds result bits 7..0
// - left justify, 10-bit: low byte holds result bits 1..0 on top, rest zero
// - 8-bit mode: low byte reads all zeros, justification ignored
// - enable bit 7 clear means shutdown, set means ready to convert
// - normal track mode: conversion begins immediately on start event
// - delayed track mode: three sar clocks of tracking before conversion
// - done flag bit 5 sets at conversion end, stays until software clears
// - busy bit 4 reads one while tracking or converting, zero when idle
// - writing one to busy starts only when source field is 000; zero ignored
// - window flag bit 3 sets on window match, stays until software clears
// - source code 001 selects timer 0 overflow
// - source codes 010, 011, 101 select further timer overflows
// - source code 100 selects rising edge of external start input
// - right justify, 10-bit: high byte is zero above bits 1..0 of top bits
// - 8-bit mode: high byte holds the whole 8-bit word
// - sar clock equals system clock divided by divider value plus one
package acc_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'hBC;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hBD;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBE;
  localparam logic [7:0] ADDR_CONTROL = 8'hE8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_ENABLE = 7;
  localparam int CTL_TRACK = 6;
  localparam int CTL_DONE = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_WINDOW = 3;
  localparam int CTL_SRC_LSB = 0;
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_LJST = 2;
  localparam int CFG_EIGHT = 1;
  localparam int CFG_GAIN = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'hF8;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // start sources and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_SOFTWARE = 3'h0;
  localparam logic [2:0] SRC_TIMER0 = 3'h1;
  localparam logic [2:0] SRC_TIMER_A = 3'h2;
  localparam logic [2:0] SRC_TIMER_B = 3'h3;
  localparam logic [2:0] SRC_EXTERNAL = 3'h4;
  localparam logic [2:0] SRC_TIMER_C = 3'h5;
  localparam logic [1:0] TRACK_EXTRA_SAR = 2'h3;
  localparam logic [3:0] CONVERT_SAR = 4'hB;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONVERT = 2'b10
  } acc_state_e;

endpackage

// file: src/acc_sar_tick.sv
// sar clock tick generator from the system clock
`timescale 1ns/1ps
module acc_sar_tick (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [4:0] divider,
  output logic tick
);
  typedef struct packed {
    logic [4:0] count;
    logic tick;
  } acc_tick_s;

  acc_tick_s s_q;
  acc_tick_s s_d;

  // one tick every divider+1 system clocks; restarts whenever run drops
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.count = 5'h00;
    end else if (s_q.count >= divider) begin
      s_d.count = 5'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.count = s_q.count + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// file: src/acc_sync.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module acc_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic first;
    logic second;
  } acc_sync_s;

  acc_sync_s s_q;
  acc_sync_s s_d;

  always_comb begin
    s_d.first = async_in;
    s_d.second = s_q.first;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.second;
endmodule

// file: src/acc_top.sv
// converter control: registers, start selection, sequencing, result format
`timescale 1ns/1ps
module acc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic timer0_overflow,
  input wire logic timer_a_overflow,
  input wire logic timer_b_overflow,
  input wire logic timer_c_overflow,
  input wire logic ext_start,
  input wire logic [9:0] core_result,
  input wire logic window_hit,
  output logic core_enable,
  output logic core_track,
  output logic core_convert,
  output logic conversion_done_pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    acc_pkg::acc_state_e state;
    logic converter_enable;
    logic track_mode_select;
    logic conversion_done_flag;
    logic window_match_flag;
    logic [2:0] start_source_select;
    logic [4:0] sar_clock_divider;
    logic left_justify_select;
    logic eight_bit_mode;
    logic gain_select;
    logic [7:0] conversion_result_low;
    logic [7:0] conversion_result_high;
    logic [3:0] sar_count;
    logic ext_prev;
    logic win_pending;
    logic [7:0] rdata;
    logic core_enable;
    logic core_track;
    logic core_convert;
    logic done_pulse;
  } acc_top_s;

  acc_top_s s_q;
  acc_top_s s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic ext_sync;
  logic sar_tick;
  logic busy;
  logic sel_event;
  logic start_evt;
  logic finish;
  logic [7:0] fmt_low;
  logic [7:0] fmt_high;
  logic ctl_write;
  logic cfg_write;
  logic low_write;
  logic high_write;
  logic hit_control;
  logic hit_config;
  logic hit_low;
  logic hit_high;
  logic ext_rise;
  logic track_last;
  logic done_set;
  logic window_set;
  logic [7:0] control_word;
  logic [7:0] config_word;

  acc_sync u_ext_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(ext_start),
    .sync_out(ext_sync)
  );

  acc_sar_tick u_sar_tick (
    .clk(clk),
    .reset_n(reset_n),
    .run(busy),
    .divider(s_q.sar_clock_divider),
    .tick(sar_tick)
  );

  assign busy = (s_q.state != acc_pkg::ST_IDLE);
  assign finish = (s_q.state == acc_pkg::ST_CONVERT) && sar_tick
    && (s_q.sar_count == acc_pkg::CONVERT_SAR);
  assign track_last = sar_tick
    && (s_q.sar_count == {2'h0, acc_pkg::TRACK_EXTRA_SAR} - 4'h1);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign hit_control = (sfr_addr == acc_pkg::ADDR_CONTROL);
  assign hit_config = (sfr_addr == acc_pkg::ADDR_CONFIG);
  assign hit_low = (sfr_addr == acc_pkg::ADDR_RESULT_LOW);
  assign hit_high = (sfr_addr == acc_pkg::ADDR_RESULT_HIGH);
  assign ctl_write = sfr_wr && hit_control;
  assign cfg_write = sfr_wr && hit_config;
  assign low_write = sfr_wr && hit_low;
  assign high_write = sfr_wr && hit_high;

  // ----------------------------------------------------------------
  // start source selection
  // ----------------------------------------------------------------
  always_comb begin
    unique case (s_q.start_source_select)
      acc_pkg::SRC_SOFTWARE: sel_event = ctl_write
        && sfr_wdata[acc_pkg::CTL_BUSY];
      acc_pkg::SRC_TIMER0: sel_event = timer0_overflow;
      acc_pkg::SRC_TIMER_A: sel_event = timer_a_overflow;
      acc_pkg::SRC_TIMER_B: sel_event = timer_b_overflow;
      acc_pkg::SRC_EXTERNAL: sel_event = ext_rise;
      acc_pkg::SRC_TIMER_C: sel_event = timer_c_overflow;
      // reserved codes never trigger
      default: sel_event = 1'b0;
    endcase
  end

  // ext_prev resets low like the idle pin, so no false edge after reset
  assign ext_rise = ext_sync && !s_q.ext_prev;

  // dropped, not queued, when busy or disabled
  assign start_evt = sel_event && s_q.converter_enable && !busy;

  // a match is judged on the cycle after the result lands
  assign done_set = finish;
  assign window_set = s_q.win_pending && window_hit;

  // ----------------------------------------------------------------
  // result formatting
  // ----------------------------------------------------------------
  always_comb begin
    if (s_q.eight_bit_mode) begin
      fmt_high = core_result[9:2];
      fmt_low = 8'h00;
    end else if (s_q.left_justify_select) begin
      fmt_high = core_result[9:2];
      fmt_low = {core_result[1:0], 6'h00};
    end else begin
      fmt_high = {6'h00, core_result[9:8]};
      fmt_low = core_result[7:0];
    end
  end

  // ----------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------
  always_comb begin
    control_word = 8'h00;
    control_word[acc_pkg::CTL_ENABLE] = s_q.converter_enable;
    control_word[acc_pkg::CTL_TRACK] = s_q.track_mode_select;
    control_word[acc_pkg::CTL_DONE] = s_q.conversion_done_flag;
    control_word[acc_pkg::CTL_BUSY] = busy;
    control_word[acc_pkg::CTL_WINDOW] = s_q.window_match_flag;
    control_word[acc_pkg::CTL_SRC_LSB +: 3] = s_q.start_source_select;
  end

  always_comb begin
    config_word = 8'h00;
    config_word[acc_pkg::CFG_DIV_LSB +: 5] = s_q.sar_clock_divider;
    config_word[acc_pkg::CFG_LJST] = s_q.left_justify_select;
    config_word[acc_pkg::CFG_EIGHT] = s_q.eight_bit_mode;
    config_word[acc_pkg::CFG_GAIN] = s_q.gain_select;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done_pulse = 1'b0;
    s_d.ext_prev = ext_sync;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (cfg_write) begin
      s_d.sar_clock_divider = sfr_wdata[acc_pkg::CFG_DIV_LSB +: 5];
      s_d.left_justify_select = sfr_wdata[acc_pkg::CFG_LJST];
      s_d.eight_bit_mode = sfr_wdata[acc_pkg::CFG_EIGHT];
      s_d.gain_select = sfr_wdata[acc_pkg::CFG_GAIN];
    end
    if (ctl_write) begin
      s_d.converter_enable = sfr_wdata[acc_pkg::CTL_ENABLE];
      s_d.track_mode_select = sfr_wdata[acc_pkg::CTL_TRACK];
      s_d.conversion_done_flag = sfr_wdata[acc_pkg::CTL_DONE];
      s_d.window_match_flag = sfr_wdata[acc_pkg::CTL_WINDOW];
      s_d.start_source_select = sfr_wdata[acc_pkg::CTL_SRC_LSB +: 3];
    end
    if (low_write) begin
      s_d.conversion_result_low = sfr_wdata;
    end
    if (high_write) begin
      s_d.conversion_result_high = sfr_wdata;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    unique case (s_q.state)
      acc_pkg::ST_IDLE: begin
        s_d.sar_count = 4'h0;
        if (start_evt) begin
          if (s_q.track_mode_select) begin
            s_d.state = acc_pkg::ST_TRACK;
          end else begin
            s_d.state = acc_pkg::ST_CONVERT;
          end
        end
      end
      acc_pkg::ST_TRACK: begin
        if (track_last) begin
          s_d.sar_count = 4'h0;
          s_d.state = acc_pkg::ST_CONVERT;
        end else if (sar_tick) begin
          s_d.sar_count = s_q.sar_count + 4'h1;
        end
      end
      acc_pkg::ST_CONVERT: begin
        if (finish) begin
          s_d.state = acc_pkg::ST_IDLE;
          s_d.sar_count = 4'h0;
          s_d.conversion_result_low = fmt_low;
          s_d.conversion_result_high = fmt_high;
          s_d.done_pulse = 1'b1;
        end else if (sar_tick) begin
          s_d.sar_count = s_q.sar_count + 4'h1;
        end
      end
      default: s_d.state = acc_pkg::ST_IDLE;
    endcase

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    s_d.win_pending = finish;

    // set beats clear on the same cycle
    if (done_set) begin
      s_d.conversion_done_flag = 1'b1;
    end
    if (window_set) begin
      s_d.window_match_flag = 1'b1;
    end

    // disabling aborts a conversion in flight
    if (!s_d.converter_enable && s_d.state != acc_pkg::ST_IDLE) begin
      s_d.state = acc_pkg::ST_IDLE;
      s_d.sar_count = 4'h0;
    end

    // ----------------------------------------------------------------
    // core controls
    // ----------------------------------------------------------------
    s_d.core_enable = s_d.converter_enable;
    s_d.core_convert = (s_d.state == acc_pkg::ST_CONVERT);
    s_d.core_track = s_d.converter_enable && !s_d.core_convert;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    s_d.rdata = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        acc_pkg::ADDR_CONTROL: s_d.rdata = control_word;
        acc_pkg::ADDR_CONFIG: s_d.rdata = config_word;
        acc_pkg::ADDR_RESULT_LOW: s_d.rdata = s_q.conversion_result_low;
        acc_pkg::ADDR_RESULT_HIGH: s_d.rdata = s_q.conversion_result_high;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.state <= acc_pkg::ST_IDLE;
      s_q.converter_enable <= acc_pkg::CONTROL_RESET[acc_pkg::CTL_ENABLE];
      s_q.track_mode_select <= acc_pkg::CONTROL_RESET[acc_pkg::CTL_TRACK];
      s_q.conversion_done_flag <= acc_pkg::CONTROL_RESET[acc_pkg::CTL_DONE];
      s_q.window_match_flag <= acc_pkg::CONTROL_RESET[acc_pkg::CTL_WINDOW];
      s_q.start_source_select <= acc_pkg::CONTROL_RESET[acc_pkg::CTL_SRC_LSB +: 3];
      s_q.sar_clock_divider <= acc_pkg::CONFIG_RESET[acc_pkg::CFG_DIV_LSB +: 5];
      s_q.left_justify_select <= acc_pkg::CONFIG_RESET[acc_pkg::CFG_LJST];
      s_q.eight_bit_mode <= acc_pkg::CONFIG_RESET[acc_pkg::CFG_EIGHT];
      s_q.gain_select <= acc_pkg::CONFIG_RESET[acc_pkg::CFG_GAIN];
      s_q.conversion_result_low <= acc_pkg::RESULT_RESET;
      s_q.conversion_result_high <= acc_pkg::RESULT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata = s_q.rdata;
  assign core_enable = s_q.core_enable;
  assign core_track = s_q.core_track;
  assign core_convert = s_q.core_convert;
  assign conversion_done_pulse = s_q.done_pulse;

endmodule

// file: tb/acc_checker.sv
// assertion checker for the converter control ports
`timescale 1ns/1ps
module acc_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic core_enable,
  input wire logic core_track,
  input wire logic core_convert,
  input wire logic conversion_done_pulse
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire ctl_rd = sfr_rd && sfr_addr == 8'hE8;
  wire ctl_wr = sfr_wr && sfr_addr == 8'hE8 && core_track && !core_convert;
  sequence s_sw_start;
    ctl_wr && sfr_wdata == 8'h90;
  endsequence
  sequence s_busy_read;
    ctl_rd && core_convert ##1 core_convert;
  endsequence
  property p_track_en; core_track |-> core_enable; endproperty
  property p_off; !core_enable [*2] |-> !core_convert; endproperty
  property p_excl; core_convert |-> !core_track; endproperty
  property p_sw_start; s_sw_start |-> ##[1:4] core_convert; endproperty
  property p_zero_wr; ctl_wr && sfr_wdata == 8'h80 |=> !core_convert [*4]; endproperty
  property p_pulse_one; conversion_done_pulse |=> !conversion_done_pulse; endproperty
  property p_pulse_cause;
    conversion_done_pulse |-> $past(core_convert) || $past(core_convert, 2);
  endproperty
  property p_done_rd;
    conversion_done_pulse && ctl_rd |=> sfr_rdata[5] && !sfr_rdata[4];
  endproperty
  property p_busy_rd; s_busy_read |-> sfr_rdata[4]; endproperty
  property p_rd_idle; !sfr_rd |=> sfr_rdata == 8'h00; endproperty
  a_track_en: assert property (p_track_en) else $error("track while off");
  a_off: assert property (p_off) else $error("converting while off");
  a_excl: assert property (p_excl) else $error("track during convert");
  a_sw_start: assert property (p_sw_start) else $error("no start");
  a_zero_wr: assert property (p_zero_wr) else $error("zero write started");
  a_pulse_one: assert property (p_pulse_one) else $error("long done pulse");
  a_pulse_cause: assert property (p_pulse_cause) else $error("stray done");
  a_done_rd: assert property (p_done_rd) else $error("done flag wrong");
  a_busy_rd: assert property (p_busy_rd) else $error("busy reads 0");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule
bind acc_top acc_checker u_chk (.clk, .reset_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
  .sfr_rdata, .core_enable, .core_track, .core_convert, .conversion_done_pulse);

// file: tb/acc_far.sv
// far-side model: timers, external start pin and converter core
`timescale 1ns/1ps
module acc_far (
  input wire logic clk,
  input wire logic fire,
  input wire logic [2:0] src,
  input wire logic [9:0] value,
  input wire logic hit,
  input wire logic core_convert,
  output logic timer0_overflow,
  output logic timer_a_overflow,
  output logic timer_b_overflow,
  output logic timer_c_overflow,
  output logic ext_start,
  output logic [9:0] core_result,
  output logic window_hit
);
  logic hold_q = 1'b0;
  logic [3:0] ext_q = 4'h0;
  always_ff @(posedge clk) begin
    hold_q <= core_convert;
    ext_q <= {ext_q[2:0], fire && src == 3'h4};
  end
  assign timer0_overflow = fire && src == 3'h1;
  assign timer_a_overflow = fire && src == 3'h2;
  assign timer_b_overflow = fire && src == 3'h3;
  assign timer_c_overflow = fire && src == 3'h5;
  assign ext_start = |ext_q;
  // outside conversion and the cycle after it the word is inverted so a stale sample shows
  assign core_result = (core_convert || hold_q) ? value : ~value;
  assign window_hit = hit;
endmodule

// file: tb/adc_conversion_control_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_conversion_control_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic fire = 1'b0;
  logic hit = 1'b0;
  logic [2:0] src = 3'h0;
  logic [9:0] value = 10'h000;
  logic [7:0] sfr_rdata, rd_q;
  logic t0, ta, tb, tc, ext, win, core_enable, core_track, core_convert, done_p;
  logic [9:0] core_result;
  logic [7:0] ra[5] = '{8'hE8, 8'hBC, 8'hBD, 8'hBE, 8'hBB};
  logic [7:0] rv[5] = '{8'h00, 8'hF8, 8'h00, 8'h00, 8'h00};
  integer seed = 32'h8681;
  integer n_errors = 0;
  integer check_count = 0;
  int exp_q[$];
  always #5 clk = ~clk;
  acc_top DUT (.clk, .reset_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
    .timer0_overflow(t0), .timer_a_overflow(ta), .timer_b_overflow(tb),
    .timer_c_overflow(tc), .ext_start(ext), .core_result, .window_hit(win),
    .core_enable, .core_track, .core_convert, .conversion_done_pulse(done_p));
  acc_far u_far (.clk, .fire, .src, .value, .hit, .core_convert, .timer0_overflow(t0),
    .timer_a_overflow(ta), .timer_b_overflow(tb), .timer_c_overflow(tc),
    .ext_start(ext), .core_result, .window_hit(win));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk); #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = v;
    @(posedge clk); #1;
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk); #1;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge clk); #1;
    v = sfr_rdata;
    sfr_rd = 1'b0;
  endtask
  task automatic convert(input logic [2:0] s, input int tm, input int lj, input int e8);
    int d, g, t, n, k, lo, hi;
    d = {$random(seed)} % 4;
    g = {$random(seed)} % 2;
    value = e8 ? 10'h155 : 10'($random(seed)); // same 8-bit word from either end
    hit = s == 3'h2;
    src = s;
    wr(8'hBC, {5'(d), 1'(lj), 1'(e8), 1'(g)});
    rd(8'hBC, rd_q);
    check(rd_q, {5'(d), 1'(lj), 1'(e8), 1'(g)});
    wr(8'hE8, {1'b1, 1'(tm), 3'b000, s});
    // a zero busy write must be seen idle for a few cycles before the start
    repeat (4) @(posedge clk);
    #1;
    if (s == 3'h0) begin
      sfr_wr = 1'b1;
      sfr_wdata = {1'b1, 1'(tm), 3'b010, s};
    end else fire = 1'b1;
    t = 1;
    n = 0;
    k = 0;
    @(posedge clk); #1;
    sfr_wr = 1'b0;
    fire = 1'b0;
    sfr_rd = 1'b1;
    while (sfr_rdata[5] !== 1'b1 && k < 600) begin
      @(posedge clk); #1;
      k++;
      if (core_convert === 1'b1) n++;
      else if (n == 0) t++;
      fire = n == 3 && s != 3'h0;
    end
    sfr_rd = 1'b0;
    hit = 1'b0;
    if (k == 600) begin
      n_errors++;
      $display("BAD t=%0t no completion", $time);
      give_verdict();
    end
    if (tm) check(8'(t > 2 * (d + 1) && t <= 3 * (d + 1) + 8), 8'h01);
    else check(8'(t <= 8), 8'h01);
    check(8'(n >= 11 * (d + 1) && n <= 12 * (d + 1) + 2), 8'h01);
    lo = e8 ? 0 : lj ? (value % 4) * 64 : value % 256;
    hi = (e8 || lj) ? value / 4 : value / 256;
    exp_q.push_back(lo);
    exp_q.push_back(hi);
    rd(8'hBD, rd_q);
    check(rd_q, 8'(exp_q.pop_front()));
    rd(8'hBE, rd_q);
    check(rd_q, 8'(exp_q.pop_front()));
    rd(8'hE8, rd_q);
    check(rd_q & 8'h38, (s == 3'h2) ? 8'h28 : 8'h20);
    wr(8'hE8, {1'b1, 1'(tm), 3'b000, s});
    n = 0;
    repeat (40) begin
      @(posedge clk); #1;
      n += core_convert;
    end
    rd(8'hE8, rd_q);
    check(rd_q & 8'h38 | 8'(n), 8'h00);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], rd_q);
      check(rd_q, rv[i]);
    end
    wr(8'hE8, 8'h10);
    rd(8'hE8, rd_q);
    check(rd_q | 8'(core_convert), 8'h00);
    wr(8'hE8, 8'h80);
    wr(8'hE8, 8'h80);
    rd(8'hE8, rd_q);
    check(rd_q & 8'h30, 8'h00);
    // codes stop at 101; 110 and 111 are never programmed
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 6; s++) begin
        convert(3'(s), {$random(seed)} % 2, m == 1, m == 2);
      end
    end
    give_verdict();
  end
endmodule
